// [design/cssw_pkg.sv]
// Functional notes
// - Accumulator A holds 4-bit data, pair holds 8-bit, carry is the bit accumulator.
// - An 8-bit stack pointer addresses a last-in first-out stack in static RAM.
// - Push decrements the pointer before writing; pop increments it after reading.
// - Stack bank select is written by 4-bit accesses; upper two bits stay zero.
// - The low two bank select bits choose stack memory bank 0 to 3.
// - With pointer zero the first push lands at address FF of bank n.
// - Stack addresses wrap inside the bank; only a bank select write moves banks.
// - Pointer is an 8-bit read/write location; bank select a 4-bit one.
// - Pointer and bank select have no reset value; software loads them first.
// - Status word low nibble is memory accessible; high nibble refuses plain access.
// - Calls push only the two bank enables; plain returns restore only those.
// - An interrupt pushes all status bits with carry; interrupt return restores all.
// - Add and subtract with carry load carry with the overflow or borrow.
// - Carry combines with a memory bit by AND, OR, XOR; move copies either way.
// - Dedicated carry ops set, clear, invert, and skip when carry is one.
// - Carry has no defined value after reset.
// - Skip flags are set and cleared by execution and are never operands.
// - Interrupt status: 0 all, 1 higher only, 2 none, 3 forbidden.
// - Accepting an interrupt saves the status and raises it by one step, holding at 2.
// - Memory bank enable selects bank select bits or fixed upper address bits.
// - Memory bank enable loads from vector bit 7 on reset and on interrupts.
// - Register bank enable loads from vector bit 6; zero forces register bank 0.
package cssw_pkg;
  localparam logic [11:0] ADDR_PSW_LOW = 12'hfb0;
  localparam logic [11:0] ADDR_PSW_HIGH = 12'hfb1;
  localparam logic [11:0] ADDR_SP = 12'hf80;
  localparam logic [11:0] ADDR_SBS = 12'hf84;
  // Low nibble: bit3 ist_hi, bit2 ist_lo, bit1 mem bank en, bit0 reg bank en.
  localparam int IST_HI_BIT = 3;
  localparam int IST_LO_BIT = 2;
  localparam int MBE_BIT = 1;
  localparam int RBE_BIT = 0;
  // High nibble: bit3 carry, bits 2..0 skip flags.
  localparam int CY_BIT = 3;
  localparam int VEC_MBE_BIT = 7;
  localparam int VEC_RBE_BIT = 6;
  localparam logic [1:0] IST_MAX = 2'h2;
  localparam logic [3:0] FIXED_BANK = 4'h0;
  localparam logic [1:0] SBS_HI_ZERO = 2'h0;

  typedef enum logic [14:0] {
    CSSW_OP_NONE = 15'h0001,
    CSSW_OP_ADD_WITH_CARRY = 15'h0002,
    CSSW_OP_SUBTRACT_WITH_CARRY = 15'h0004,
    CSSW_OP_SET = 15'h0008,
    CSSW_OP_CLR = 15'h0010,
    CSSW_OP_NOT = 15'h0020,
    CSSW_OP_SKT = 15'h0040,
    CSSW_OP_AND = 15'h0080,
    CSSW_OP_OR = 15'h0100,
    CSSW_OP_XOR = 15'h0200,
    CSSW_OP_MOVTO = 15'h0400,
    CSSW_OP_MOVFROM = 15'h0800,
    CSSW_OP_CALL = 15'h1000,
    CSSW_OP_RET = 15'h2000,
    CSSW_OP_RETURN_FROM_INTERRUPT = 15'h4000
  } cssw_op_type;

  typedef struct packed {
    logic cy;
    logic [2:0] sk;
    logic [1:0] ist;
    logic memory_bank_enable;
    logic register_bank_enable;
  } cssw_psw_type;

  typedef struct packed {
    logic en;
    logic wr;
    logic wide;
    logic [11:0] addr;
    logic [7:0] wdata;
  } cssw_mem_type;
endpackage : cssw_pkg

// [design/cssw_alu.sv]
`timescale 1ns/1ps
`default_nettype none
module cssw_alu (
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic cin,
  input wire logic sub,
  output logic [3:0] sum,
  output logic cout
);
  logic [4:0] full;
  // Carry out on add, borrow on subtract.
  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {4'h0, cin};
    end else begin
      full = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    end
    sum = full[3:0];
    cout = full[4];
  end
endmodule : cssw_alu
`default_nettype wire

// [design/cssw_core.sv]
`timescale 1ns/1ps
`default_nettype none
module cssw_core (
  input wire logic clk,
  input wire logic rstn,
  input wire cssw_pkg::cssw_op_type op,
  input wire logic op_valid,
  input wire logic [3:0] alu_b,
  input wire logic mem_bit,
  input wire logic acc_wr,
  input wire logic [3:0] acc_wdata,
  input wire logic pair_wr,
  input wire logic [7:0] pair_wdata,
  input wire cssw_pkg::cssw_mem_type mem_req,
  input wire logic push,
  input wire logic pop,
  input wire logic irq_accept,
  input wire logic [7:0] vector_byte,
  input wire logic vector_load,
  input wire logic [7:0] stack_rdata,
  input wire logic [2:0] skip_next,
  input wire logic skip_load,
  input wire logic [3:0] mem_bank_select,
  input wire logic [1:0] reg_bank_select,
  output logic [3:0] acc_a,
  output logic [7:0] pair_acc,
  output logic [11:0] stack_addr,
  output logic [7:0] stack_wdata,
  output logic stack_we,
  output logic [7:0] mem_rdata,
  output logic mem_refused,
  output logic carry_flag,
  output logic bit_out,
  output logic skip_req,
  output logic [1:0] interrupt_status,
  output logic [3:0] data_bank,
  output logic [1:0] reg_bank
);
  logic [7:0] sp_reg;
  logic [1:0] sbs_reg;
  logic cy_reg;
  logic [2:0] sk_reg;
  logic [1:0] ist_reg;
  logic mbe_reg;
  logic rbe_reg;
  logic [3:0] acc_reg;
  logic [7:0] pair_reg;
  logic [3:0] alu_sum;
  logic alu_cout;
  logic [7:0] sp_next;
  logic wr_sp;
  logic wr_sbs;
  logic wr_psw_lo;
  logic is_arith;
  logic ret_any;
  cssw_pkg::cssw_psw_type saved;

  assign wr_sp = mem_req.en && mem_req.wr && mem_req.wide && mem_req.addr == cssw_pkg::ADDR_SP;
  assign wr_sbs = mem_req.en && mem_req.wr && !mem_req.wide && mem_req.addr == cssw_pkg::ADDR_SBS;
  // Upper half is refused for plain data access.
  assign wr_psw_lo = mem_req.en && mem_req.wr && !mem_req.wide
                     && mem_req.addr == cssw_pkg::ADDR_PSW_LOW;
  assign is_arith = op_valid && (op == cssw_pkg::CSSW_OP_ADD_WITH_CARRY || op == cssw_pkg::CSSW_OP_SUBTRACT_WITH_CARRY);
  assign ret_any = op_valid && (op == cssw_pkg::CSSW_OP_RET || op == cssw_pkg::CSSW_OP_RETURN_FROM_INTERRUPT);
  assign saved = cssw_pkg::cssw_psw_type'(stack_rdata);

  cssw_alu cssw_alu_i (
    .a(acc_reg),
    .b(alu_b),
    .cin(cy_reg),
    .sub(op == cssw_pkg::CSSW_OP_SUBTRACT_WITH_CARRY),
    .sum(alu_sum),
    .cout(alu_cout)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= 4'h0;
      pair_reg <= 8'h00;
    end else if (is_arith) begin
      acc_reg <= alu_sum;
      pair_reg <= {pair_reg[7:4], alu_sum};
    end else if (pair_wr) begin
      pair_reg <= pair_wdata;
      acc_reg <= pair_wdata[3:0];
    end else if (acc_wr) begin
      acc_reg <= acc_wdata;
      pair_reg <= {pair_reg[7:4], acc_wdata};
    end
  end

  // pre-decrement on push, post-increment on pop
  always_comb begin
    sp_next = sp_reg;
    if (push) begin
      sp_next = sp_reg - 8'h01;
    end else if (pop) begin
      sp_next = sp_reg + 8'h01;
    end
  end

  // no reset on pointer and bank
  always_ff @(posedge clk) begin
    if (wr_sp) begin
      sp_reg <= mem_req.wdata;
    end else begin
      sp_reg <= sp_next;
    end
    if (wr_sbs) begin
      sbs_reg <= mem_req.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (op_valid && op == cssw_pkg::CSSW_OP_RETURN_FROM_INTERRUPT) begin
      cy_reg <= saved.cy;
    end else if (is_arith) begin
      cy_reg <= alu_cout;
    end else if (op_valid) begin
      case (op)
        cssw_pkg::CSSW_OP_SET: cy_reg <= 1'b1;
        cssw_pkg::CSSW_OP_CLR: cy_reg <= 1'b0;
        cssw_pkg::CSSW_OP_NOT: cy_reg <= ~cy_reg;
        cssw_pkg::CSSW_OP_AND: cy_reg <= cy_reg & mem_bit;
        cssw_pkg::CSSW_OP_OR: cy_reg <= cy_reg | mem_bit;
        cssw_pkg::CSSW_OP_XOR: cy_reg <= cy_reg ^ mem_bit;
        cssw_pkg::CSSW_OP_MOVFROM: cy_reg <= mem_bit;
        default: cy_reg <= cy_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sk_reg <= 3'h0;
    end else if (op_valid && op == cssw_pkg::CSSW_OP_RETURN_FROM_INTERRUPT) begin
      sk_reg <= saved.sk;
    end else if (skip_load) begin
      sk_reg <= skip_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ist_reg <= 2'h0;
    end else if (op_valid && op == cssw_pkg::CSSW_OP_RETURN_FROM_INTERRUPT) begin
      ist_reg <= saved.ist;
    end else if (irq_accept) begin
      // raise one step, saturating at none
      if (ist_reg < cssw_pkg::IST_MAX) begin
        ist_reg <= ist_reg + 2'h1;
      end
    end else if (wr_psw_lo) begin
      // Software relies on interrupts being masked around this write.
      ist_reg <= {mem_req.wdata[cssw_pkg::IST_HI_BIT], mem_req.wdata[cssw_pkg::IST_LO_BIT]};
    end
  end

  // Bank enables start at zero until the reset vector byte is delivered.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mbe_reg <= 1'b0;
      rbe_reg <= 1'b0;
    end else if (vector_load) begin
      mbe_reg <= vector_byte[cssw_pkg::VEC_MBE_BIT];
      rbe_reg <= vector_byte[cssw_pkg::VEC_RBE_BIT];
    end else if (ret_any) begin
      mbe_reg <= saved.memory_bank_enable;
      rbe_reg <= saved.register_bank_enable;
    end else if (wr_psw_lo) begin
      mbe_reg <= mem_req.wdata[cssw_pkg::MBE_BIT];
      rbe_reg <= mem_req.wdata[cssw_pkg::RBE_BIT];
    end
  end

  // Stack port is registered; the sequencer sees address and data one cycle after push.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_addr <= 12'h000;
      stack_wdata <= 8'h00;
      stack_we <= 1'b0;
    end else begin
      stack_we <= push;
      stack_addr <= {2'h0, sbs_reg, push ? sp_next : sp_reg};
      if (irq_accept) begin
        stack_wdata <= {cy_reg, sk_reg, ist_reg, mbe_reg, rbe_reg};
      end else begin
        stack_wdata <= {6'h00, mbe_reg, rbe_reg};
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_rdata <= 8'h00;
      mem_refused <= 1'b0;
    end else begin
      mem_refused <= mem_req.en && mem_req.addr == cssw_pkg::ADDR_PSW_HIGH;
      case (mem_req.addr)
        cssw_pkg::ADDR_SP: mem_rdata <= sp_reg;
        cssw_pkg::ADDR_SBS: mem_rdata <= {4'h0, cssw_pkg::SBS_HI_ZERO, sbs_reg};
        cssw_pkg::ADDR_PSW_LOW: mem_rdata <= {4'h0, ist_reg, mbe_reg, rbe_reg};
        default: mem_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_a <= 4'h0;
      pair_acc <= 8'h00;
      carry_flag <= 1'b0;
      bit_out <= 1'b0;
      skip_req <= 1'b0;
      interrupt_status <= 2'h0;
      data_bank <= cssw_pkg::FIXED_BANK;
      reg_bank <= 2'h0;
    end else begin
      acc_a <= acc_reg;
      pair_acc <= pair_reg;
      carry_flag <= cy_reg;
      bit_out <= cy_reg;
      skip_req <= op_valid && op == cssw_pkg::CSSW_OP_SKT && cy_reg;
      interrupt_status <= ist_reg;
      data_bank <= mbe_reg ? mem_bank_select : cssw_pkg::FIXED_BANK;
      reg_bank <= rbe_reg ? reg_bank_select : 2'h0;
    end
  end
endmodule : cssw_core
`default_nettype wire

// [testbench/cssw_core_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module cssw_core_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire cssw_pkg::cssw_op_type op,
  input wire logic op_valid,
  input wire logic push,
  input wire logic irq_accept,
  input wire cssw_pkg::cssw_mem_type mem_req,
  input wire logic [11:0] stack_addr,
  input wire logic stack_we,
  input wire logic mem_refused,
  input wire logic carry_flag,
  input wire logic skip_req,
  input wire logic [1:0] interrupt_status
);
  logic hi_req;
  assign hi_req = mem_req.en && (mem_req.addr == cssw_pkg::ADDR_PSW_HIGH);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence two_push;
    push ##1 push;
  endsequence
  AST_PUSH_WE: assert property (push |=> stack_we) else $error("push lost");
  AST_PUSH_DEC: assert property (two_push |=> stack_addr[7:0] == $past(stack_addr[7:0]) - 8'h01)
    else $error("pointer not decremented");
  AST_BANK_KEPT: assert property (two_push |=> stack_addr[11:8] == $past(stack_addr[11:8]))
    else $error("stack left its bank");
  AST_BANK_TOP: assert property (stack_we |-> stack_addr[11:10] == 2'h0)
    else $error("bank select upper bits set");
  AST_REFUSE: assert property (hi_req |=> mem_refused) else $error("high word not refused");
  AST_REFUSE_CAUSE: assert property (mem_refused |-> $past(hi_req))
    else $error("refusal without cause");
  AST_CY_SET: assert property (op_valid && op == cssw_pkg::CSSW_OP_SET |=> ##[0:1] carry_flag)
    else $error("carry not set");
  AST_CY_CLR: assert property (op_valid && op == cssw_pkg::CSSW_OP_CLR |=> ##[0:1] !carry_flag)
    else $error("carry not cleared");
  AST_SKIP: assert property (op_valid && op == cssw_pkg::CSSW_OP_SKT && carry_flag |=> ##[0:1]
    skip_req) else $error("no skip on carry");
  AST_IST_LEGAL: assert property (interrupt_status != 2'h3) else $error("status three");
  AST_IST_RAISE: assert property (irq_accept && interrupt_status == 2'h0 |=> ##[0:1]
    interrupt_status == 2'h1) else $error("status not raised");
endmodule : cssw_core_sva
bind cssw_core cssw_core_sva cssw_core_sva_i (.clk(clk), .rstn(rstn), .op(op),
  .op_valid(op_valid), .push(push), .irq_accept(irq_accept), .mem_req(mem_req),
  .stack_addr(stack_addr), .stack_we(stack_we), .mem_refused(mem_refused),
  .carry_flag(carry_flag), .skip_req(skip_req), .interrupt_status(interrupt_status));
`default_nettype wire

// [testbench/cssw_stack_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cssw_stack_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stack_we,
  input wire logic [7:0] stack_wdata,
  input wire logic pop,
  output logic [7:0] stack_rdata
);
  logic [7:0] mem_reg [0:15];
  logic [3:0] cnt_reg;
  logic [7:0] last_reg;
  always_ff @(posedge clk) begin
    if (stack_we) begin
      mem_reg[cnt_reg] <= stack_wdata;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      last_reg <= 8'h5a;
    end else begin
      last_reg <= stack_rdata;
      if (stack_we) begin
        cnt_reg <= cnt_reg + 4'h1;
      end else if (pop) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
  // Outside a pop nothing drives the bus, so the byte flips every cycle.
  assign stack_rdata = pop ? mem_reg[cnt_reg - 4'h1] : ~last_reg;
endmodule : cssw_stack_model
`default_nettype wire

// [testbench/cpu_stack_and_status_word_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_and_status_word_bench;
  logic clk, rstn, op_valid, mem_bit, acc_wr, pair_wr, push, pop, irq_accept, vector_load;
  logic skip_load, stack_we, mem_refused, carry_flag, bit_out, skip_req, c;
  logic [3:0] alu_b, acc_wdata, mem_bank_select, acc_a, data_bank;
  logic [7:0] pair_wdata, vector_byte, stack_rdata, pair_acc, stack_wdata, mem_rdata, sp;
  logic [2:0] skip_next;
  logic [1:0] reg_bank_select, interrupt_status, reg_bank;
  logic [11:0] stack_addr;
  logic [31:0] r, seed;
  logic [4:0] sum, dif;
  logic [27:0] e;
  logic [27:0] q [$];
  cssw_pkg::cssw_op_type op;
  cssw_pkg::cssw_mem_type mem_req;
  int n_fail, comparisons, n_ref, n_skip, k, j, s, ns;
  int seq [12] = '{3, 6, 4, 6, 5, 7, 8, 9, 11, 10, 1, 2};
  cssw_core cssw_core_i (.clk, .rstn, .op, .op_valid, .alu_b, .mem_bit, .acc_wr, .acc_wdata,
    .pair_wr, .pair_wdata, .mem_req, .push, .pop, .irq_accept, .vector_byte, .vector_load,
    .stack_rdata, .skip_next, .skip_load, .mem_bank_select, .reg_bank_select, .acc_a,
    .pair_acc, .stack_addr, .stack_wdata, .stack_we, .mem_rdata, .mem_refused, .carry_flag,
    .bit_out, .skip_req, .interrupt_status, .data_bank, .reg_bank);
  cssw_stack_model cssw_stack_model_i (.clk, .rstn, .stack_we, .stack_wdata, .pop,
    .stack_rdata);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic fire(input int n);
    repeat (n) @(negedge clk);
    {op_valid, acc_wr, pair_wr, push, pop, irq_accept, vector_load, skip_load} = 8'h00;
    mem_req.en = 1'b0;
    repeat (2) @(negedge clk);
  endtask : fire
  task automatic mem(input logic [11:0] a, input logic w, input logic wd, input logic [7:0] d);
    mem_req = '{1'b1, w, wd, a, d};
    fire(1);
  endtask : mem
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  always @(negedge clk) begin
    if (stack_we === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : '1;
      chk(stack_addr, e[19:8]);
      chk({4'h0, stack_wdata & e[27:20]}, {4'h0, e[7:0]});
    end
    if (mem_refused === 1'b1) n_ref++;
    if (skip_req === 1'b1) n_skip++;
  end
  initial begin
    seed = 32'hef1b;
    {n_fail, comparisons, n_ref, n_skip} = '0;
    {op_valid, alu_b, mem_bit, acc_wr, acc_wdata, pair_wr, pair_wdata, push, pop} = '0;
    {irq_accept, vector_byte, vector_load, skip_next, skip_load} = '0;
    op = cssw_pkg::CSSW_OP_NONE;
    mem_req = '0;
    r = rnd();
    mem_bank_select = r[3:0];
    reg_bank_select = r[5:4];
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    for (k = 0; k < 4; k++) begin
      r = rnd();
      mem(cssw_pkg::ADDR_SBS, 1'b1, 1'b0, {4'h0, r[1:0], k[1:0]});
      mem(cssw_pkg::ADDR_SBS, 1'b0, 1'b0, 8'h00);
      chk({8'h0, mem_rdata[3:0]}, {10'h0, k[1:0]});
      mem(cssw_pkg::ADDR_PSW_LOW, 1'b1, 1'b0, {6'h0, k[1:0]});
      mem(cssw_pkg::ADDR_PSW_LOW, 1'b0, 1'b0, 8'h00);
      chk({8'h0, mem_rdata[3:0]}, {10'h0, k[1:0]});
      chk({8'h0, data_bank}, {8'h0, k[1] ? mem_bank_select : cssw_pkg::FIXED_BANK});
      chk({10'h0, reg_bank}, {10'h0, k[0] ? reg_bank_select : 2'h0});
      sp = {7'h0, k[0]};
      mem(cssw_pkg::ADDR_SP, 1'b1, 1'b1, sp);
      mem(cssw_pkg::ADDR_SP, 1'b0, 1'b1, 8'h00);
      chk({4'h0, mem_rdata}, {4'h0, sp});
      repeat (2) begin
        sp = sp - 8'h01;
        q.push_back({8'h03, 2'h0, k[1:0], sp, 6'h0, k[1:0]});
      end
      push = 1'b1;
      op = cssw_pkg::CSSW_OP_CALL;
      op_valid = 1'b1;
      fire(2);
    end
    mem(cssw_pkg::ADDR_PSW_HIGH, 1'b1, 1'b0, 8'h0f);
    mem(cssw_pkg::ADDR_PSW_HIGH, 1'b0, 1'b0, 8'h00);
    chk({4'h0, mem_rdata}, 12'h000);
    chk(12'(n_ref), 12'h002);
    for (j = 0; j < 24; j++) begin
      r = rnd();
      {acc_wr, pair_wr, acc_wdata, pair_wdata} = {2'h3, r[3:0], r[23:20], r[3:0]};
      fire(1);
      chk({8'h0, acc_a}, {8'h0, r[3:0]});
      chk({4'h0, pair_acc}, {4'h0, r[23:20], r[3:0]});
      {alu_b, mem_bit} = {r[7:4], r[8]};
      s = seq[j % 12];
      op = cssw_pkg::cssw_op_type'(15'h0001 << s);
      op_valid = 1'b1;
      sum = {1'b0, r[3:0]} + {1'b0, r[7:4]} + {4'h0, c};
      dif = {1'b0, r[3:0]} - {1'b0, r[7:4]} - {4'h0, c};
      ns = n_skip + ((s == 6 && c) ? 1 : 0);
      case (s)
        1: c = sum[4];
        2: c = dif[4];
        3: c = 1'b1;
        4: c = 1'b0;
        5: c = ~c;
        7: c = c & r[8];
        8: c = c | r[8];
        9: c = c ^ r[8];
        11: c = r[8];
        default: ;
      endcase
      fire(1);
      chk({11'h0, carry_flag}, {11'h0, c});
      if (s == 10) chk({11'h0, bit_out}, {11'h0, c});
      if (s < 3) chk({8'h0, acc_a}, {8'h0, s == 1 ? sum[3:0] : dif[3:0]});
      chk(12'(n_skip), 12'(ns));
    end
    r = rnd();
    skip_next = r[2:0];
    skip_load = 1'b1;
    fire(1);
    mem(cssw_pkg::ADDR_PSW_LOW, 1'b1, 1'b0, 8'h03);
    for (k = 0; k < 3; k++) begin
      sp = sp - 8'h01;
      q.push_back({8'hff, 4'h3, sp, c, r[2:0], k[1:0], 2'h3});
      irq_accept = 1'b1;
      push = 1'b1;
      fire(1);
      chk({10'h0, interrupt_status}, (k == 0) ? 12'h001 : 12'h002);
    end
    for (k = 2; k >= 0; k--) begin
      pop = 1'b1;
      op = cssw_pkg::CSSW_OP_RETURN_FROM_INTERRUPT;
      op_valid = 1'b1;
      fire(1);
      chk({10'h0, interrupt_status}, {10'h0, k[1:0]});
    end
    chk({11'h0, carry_flag}, {11'h0, c});
    mem(cssw_pkg::ADDR_PSW_LOW, 1'b1, 1'b0, 8'h00);
    pop = 1'b1;
    op = cssw_pkg::CSSW_OP_RET;
    op_valid = 1'b1;
    fire(1);
    chk({8'h0, data_bank}, {8'h0, mem_bank_select});
    chk({10'h0, interrupt_status}, 12'h000);
    chk({11'h0, carry_flag}, {11'h0, c});
    r = rnd();
    vector_byte = r[7:0];
    vector_load = 1'b1;
    fire(1);
    chk({8'h0, data_bank}, {8'h0, r[7] ? mem_bank_select : cssw_pkg::FIXED_BANK});
    chk({10'h0, reg_bank}, {10'h0, r[6] ? reg_bank_select : 2'h0});
    chk(12'(q.size()), 12'h000);
    stop_test();
  end
endmodule : cpu_stack_and_status_word_bench
`default_nettype wire
